// >>> rtl/pic_defines.vh
// register offsets, field positions and reset values of the peripheral interrupt controller
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH
`define PIC_OFS_FLAGS_A   12'h000
`define PIC_OFS_FLAGS_B   12'h004
`define PIC_OFS_MASK_A    12'h008
`define PIC_OFS_MASK_B    12'h00C
`define PIC_OFS_SYS_CTRL  12'h010
`define PIC_OFS_STATUS    12'h014
`define PIC_BIT_COUNTER_ZERO  3
`define PIC_BIT_COUNTER_MATCH 2
`define PIC_BIT_PIN_PAIR_B    1
`define PIC_BIT_PIN_PAIR_A    0
`define PIC_BIT_ONE_HERTZ     3
`define PIC_BIT_FAST_TICK     2
`define PIC_BIT_LEVEL_DETECT  1
`define PIC_BIT_SERIAL_DONE   0
`define PIC_BIT_GLOBAL_EN     0
`define PIC_RST_FLAGS     4'h0
`define PIC_RST_MASK      4'h0
`define PIC_RST_GLOBAL_EN 1'b0
`endif

// >>> rtl/pic_top.v
// peripheral interrupt controller with apb register slave
// Operation
// - nine request sources on eight flags, each flag with its own mask bit
// - cpu interrupt only while any flag set and global enable is one
// - flag sets only on rising request edge with its mask bit one
// - reset clears all masks and forces global enable to zero
// - reading a flag register returns old value then clears that register
// - writing one clears that flag only; zero leaves it unchanged
// - request with mask cleared is discarded, never recorded
// - flag latching ignores global enable state
// - entering halt mode sets global enable to one
// - level detect low and pin compare share one flag and mask
// - requests caught during service stay pending and re-raise interrupt
// - flags a: counter zero, counter match, pin pair b, pin pair a
// - flags b: one hertz, fast tick, level detect, serial done
// - mask a mirrors flags a bit for bit
// - mask b mirrors flags b bit for bit
// - serial source requests when a full 8 bit transfer ends
// - level detector requests at measurement end only when level low
// - reading flags b also clears the level detect flag
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "pic_defines.vh"
module pic_top #(
    parameter ADDR_WIDTH = 12
) (
    // clock and reset
    input  wire                  sys_clk,
    input  wire                  reset,
    // apb slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [ADDR_WIDTH-1:0] paddr,
    input  wire [31:0]           pwdata,
    input  wire [3:0]            pstrb,
    output reg  [31:0]           prdata,
    output reg                   pready,
    output reg                   pslverr,
    // peripheral requests, same clock domain
    input  wire                  counter_at_zero,
    input  wire                  counter_compare_hit,
    input  wire                  pin_pair_b_req,
    input  wire                  pin_pair_a_req,
    input  wire                  prescaler_last_stage,
    input  wire                  fast_tick_req,
    input  wire                  level_measure_done,
    input  wire                  level_measure_low,
    input  wire                  pin_level_compare,
    input  wire                  serial_byte_done,
    // cpu side
    input  wire                  halt_enter,
    output reg                   cpu_irq
);

    reg  [3:0]  irq_flags_a_q;
    reg  [3:0]  irq_flags_b_q;
    reg  [3:0]  irq_mask_a_q;
    reg  [3:0]  irq_mask_b_q;
    reg         global_irq_enable_q;
    reg  [7:0]  req_prev_q;
    wire [7:0]  req_now;
    wire [7:0]  req_rise;
    wire [7:0]  mask_all;
    wire        level_detect_req;
    wire        access;
    wire        wr;
    wire        rd;
    wire        hit_flags_a;
    wire        hit_flags_b;
    wire        hit_mask_a;
    wire        hit_mask_b;
    wire        hit_sys;
    wire        hit_status;
    wire        mapped;
    reg  [3:0]  clr_a;
    reg  [3:0]  clr_b;
    reg  [31:0] rdata_d;

    function sel_hit;
        input [ADDR_WIDTH-1:0] addr;
        input [11:0]           ofs;
        begin
            sel_hit = (addr[11:0] == ofs);
        end
    endfunction

    // level result only counts at end of measurement; shares a line with pin compare
    assign level_detect_req = (level_measure_done & level_measure_low) | pin_level_compare;

    // bit order follows the flag register layouts
    assign req_now = {prescaler_last_stage, fast_tick_req, level_detect_req, serial_byte_done,
                      counter_at_zero, counter_compare_hit, pin_pair_b_req, pin_pair_a_req};

    assign req_rise = req_now & ~req_prev_q;
    assign mask_all = {irq_mask_b_q, irq_mask_a_q};

    // a zero-wait slave: every access completes in its first access cycle
    assign access      = psel & penable;
    assign wr          = access & pwrite & pstrb[0];
    assign rd          = access & ~pwrite;
    assign hit_flags_a = sel_hit(paddr, `PIC_OFS_FLAGS_A);
    assign hit_flags_b = sel_hit(paddr, `PIC_OFS_FLAGS_B);
    assign hit_mask_a  = sel_hit(paddr, `PIC_OFS_MASK_A);
    assign hit_mask_b  = sel_hit(paddr, `PIC_OFS_MASK_B);
    assign hit_sys     = sel_hit(paddr, `PIC_OFS_SYS_CTRL);
    assign hit_status  = sel_hit(paddr, `PIC_OFS_STATUS);
    assign mapped      = hit_flags_a | hit_flags_b | hit_mask_a | hit_mask_b | hit_sys | hit_status;

    always @* begin
        clr_a = 4'h0;
        clr_b = 4'h0;
        if (rd && hit_flags_a) begin
            clr_a = 4'hF;
        end
        if (rd && hit_flags_b) begin
            clr_b = 4'hF;
        end
        if (wr && hit_flags_a) begin
            clr_a = clr_a | pwdata[3:0];
        end
        if (wr && hit_flags_b) begin
            clr_b = clr_b | pwdata[3:0];
        end
    end

    always @* begin
        rdata_d = 32'h0000_0000;
        if (hit_flags_a) begin
            rdata_d[3:0] = irq_flags_a_q;
        end else if (hit_flags_b) begin
            rdata_d[3:0] = irq_flags_b_q;
        end else if (hit_mask_a) begin
            rdata_d[3:0] = irq_mask_a_q;
        end else if (hit_mask_b) begin
            rdata_d[3:0] = irq_mask_b_q;
        end else if (hit_sys) begin
            rdata_d[`PIC_BIT_GLOBAL_EN] = global_irq_enable_q;
        end else if (hit_status) begin
            rdata_d[0] = cpu_irq;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            req_prev_q <= 8'h00;
        end else begin
            req_prev_q <= req_now;
        end
    end

    // a new edge beats a clear in the same cycle so no event is lost
    always @(posedge sys_clk) begin
        if (reset) begin
            irq_flags_a_q <= `PIC_RST_FLAGS;
            irq_flags_b_q <= `PIC_RST_FLAGS;
        end else begin
            irq_flags_a_q <= (irq_flags_a_q & ~clr_a) | (req_rise[3:0] & mask_all[3:0]);
            irq_flags_b_q <= (irq_flags_b_q & ~clr_b) | (req_rise[7:4] & mask_all[7:4]);
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            irq_mask_a_q        <= `PIC_RST_MASK;
            irq_mask_b_q        <= `PIC_RST_MASK;
            global_irq_enable_q <= `PIC_RST_GLOBAL_EN;
        end else begin
            if (wr && hit_mask_a) begin
                irq_mask_a_q <= pwdata[3:0];
            end
            if (wr && hit_mask_b) begin
                irq_mask_b_q <= pwdata[3:0];
            end
            // halt wins over a software write in the same cycle so the core can wake
            if (halt_enter) begin
                global_irq_enable_q <= 1'b1;
            end else if (wr && hit_sys) begin
                global_irq_enable_q <= pwdata[`PIC_BIT_GLOBAL_EN];
            end
        end
    end

    // output is one cycle behind the flags; no priority among sources
    always @(posedge sys_clk) begin
        if (reset) begin
            cpu_irq <= 1'b0;
        end else begin
            cpu_irq <= global_irq_enable_q & ((|irq_flags_a_q) | (|irq_flags_b_q));
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

endmodule // pic_top

// >>> dv/pic_chk_sva.sv
// port assertions of the interrupt controller
`timescale 1ns/100ps
module pic_chk (
    // bus and cpu side
    input wire        sys_clk,
    input wire        reset,
    input wire        psel,
    input wire        penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        cpu_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    rdy_setup_a: assert property (psel && !penable |=> pready) else $error("late ready");
    rdy_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    rdy_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
    err_hole_a: assert property (pready && paddr > 12'h014 |-> pslverr) else $error("no error");
    rd_nibble_a: assert property (pready |-> prdata[31:4] == 28'h0) else $error("wide");
    irq_reset_a: assert property ($past(reset) |-> !cpu_irq) else $error("irq in reset");
    // a flag only leaves by a read or write-1, so a drop needs an access two edges back
    irq_fall_a: assert property ($fell(cpu_irq) |-> $past(pready, 2)) else $error("drop");
    cover property (pready && pslverr);
    cover property ($rose(cpu_irq));
    cover property ($fell(cpu_irq));
endmodule // pic_chk
bind pic_top pic_chk chk (.*);

// >>> dv/pic_cpu_model.sv
// cpu core stand-in that halts and wakes on the interrupt
`timescale 1ns/100ps
module pic_cpu_model (
    // halt request and wake
    input  wire  sys_clk,
    input  wire  sleep_cmd,
    input  wire  cpu_irq,
    output logic halt_enter = 1'b0
);
    // one service routine, so the software picks the order itself
    always @(posedge sys_clk) halt_enter <= sleep_cmd && !cpu_irq;
endmodule // pic_cpu_model

// >>> dv/pic_tb.sv
// bench for the interrupt controller
`timescale 1ns/100ps
module testbench;
    logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, sleep_cmd = 1'b0, pready, pslverr, cpu_irq, halt_enter;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rv;
    logic [3:0]  pstrb = 4'hF;
    logic [9:0]  rq = '0;
    int          err_total = 0, checks = 0;
    always #50 sys_clk = ~sys_clk;
    pic_top dut (.*, .counter_at_zero(rq[9]), .counter_compare_hit(rq[8]),
        .pin_pair_b_req(rq[7]), .pin_pair_a_req(rq[6]), .prescaler_last_stage(rq[5]),
        .fast_tick_req(rq[4]), .level_measure_done(rq[3]), .level_measure_low(rq[2]),
        .pin_level_compare(rq[1]), .serial_byte_done(rq[0]));
    pic_cpu_model cpu (.sys_clk(sys_clk), .sleep_cmd(sleep_cmd), .cpu_irq(cpu_irq),
        .halt_enter(halt_enter));
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        checks++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, x, s);
        end
    endtask
    // rv holds read data with the error response folded into bit 31
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
        if (n >= 20) err_total++;
        rv = {pslverr, prdata[30:0]};
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] x);
        apb(1'b0, a, '0);
        chk($sformatf("reg %h", a), rv, x);
    endtask
    task automatic pulse(logic [9:0] m);
        @(posedge sys_clk);
        rq <= m;
        @(posedge sys_clk);
        rq <= '0;
    endtask
    task automatic t_reset();
        for (int a = 0; a < 28; a += 4) rd(a[11:0], a == 24 ? 32'h80000000 : 32'h0);
        pulse(10'h3FF);
        rd(12'h000, 32'h0);
        apb(1'b1, 12'h008, 32'hF);
        apb(1'b1, 12'h00C, 32'hF);
        rd(12'h00C, 32'hF);
        // a write whose low byte lane is off must leave the mask alone
        pstrb <= 4'h0;
        apb(1'b1, 12'h008, 32'h0);
        pstrb <= 4'hF;
        rd(12'h008, 32'hF);
        $display("reset and mask test done");
    endtask
    task automatic t_flags();
        logic [9:0] s [10] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
            10'h00C, 10'h002, 10'h001, 10'h008};
        logic [4:0] e [10] = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h18, 5'h14, 5'h12, 5'h12,
            5'h11, 5'h10};
        for (int i = 0; i < 10; i++) begin
            pulse(s[i]);
            rd({9'h0, e[i][4], 2'b00}, {28'h0, e[i][3:0]});
            rd({9'h0, e[i][4], 2'b00}, 32'h0);
        end
        $display("flag layout test done");
    endtask
    task automatic t_irq();
        int n;
        n = 0;
        pulse(10'h300);
        repeat (3) @(posedge sys_clk);
        chk("irq", cpu_irq, 32'h0);
        apb(1'b1, 12'h000, 32'h8);
        sleep_cmd <= 1'b1;
        while (cpu_irq !== 1'b1 && n++ < 20) @(posedge sys_clk);
        sleep_cmd <= 1'b0;
        chk("wake", cpu_irq, 32'h1);
        rd(12'h010, 32'h1);
        rd(12'h000, 32'h4);
        repeat (3) @(posedge sys_clk);
        chk("irq", cpu_irq, 32'h0);
        pulse(10'h001);
        repeat (2) @(posedge sys_clk);
        chk("irq", cpu_irq, 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        repeat (3) @(posedge sys_clk);
        chk("irq", cpu_irq, 32'h0);
        $display("irq test done");
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_flags();
        t_irq();
        close_out();
    end
    initial begin
        #1000000;
        err_total++;
        close_out();
    end
endmodule // testbench
